/* dv/parts_life_alarm_monitor_tb.sv */
// Self-checking bench for the parts life monitor
`timescale 1ns/1ps
module parts_life_alarm_monitor_tb;
  logic        clk, rst, reg_wr, reg_rd, power_req, supply_on, inrush_switch_on, chk;
  logic        drive_running, motor_connected, motor_rotating, motor_undersized;
  logic        run_command, output_shutoff_input, fault_stop, dc_inject_out;
  logic        fan_fault_indication, life_alarm_out, irq;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata, exp_v, r;
  logic [7:0]  heatsink_temp;
  logic [6:0]  cap_measure_pct, fan_speed_pct;
  logic [2:0]  terminal_out;
  logic [13:0] fan2_pct;
  logic        fan2_fault;
  logic [15:0] exp_q[$];
  logic [31:0] seed = 32'h26b9941d;
  int          n_mismatch = 0, compares = 0, cyc = 0, i;
`define CHK(name, exp, got) \
  begin compares++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("MISMATCH %s exp %h got %h", name, exp, got); end end
  parts_life_alarm_monitor #(.FAN_COUNT(1), .DC_INJECT_CYCLES(20), .LIFE_TICK_CYCLES(4),
    .CTRL_CAP_STEP(16'h0002), .TERM_COUNT(3)) dut_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .inrush_switch_on(inrush_switch_on),
    .supply_on(supply_on), .drive_running(drive_running), .heatsink_temp(heatsink_temp),
    .motor_connected(motor_connected), .motor_rotating(motor_rotating),
    .motor_undersized(motor_undersized), .run_command(run_command),
    .output_shutoff_input(output_shutoff_input), .fault_stop(fault_stop),
    .cap_measure_pct(cap_measure_pct), .fan_speed_pct(fan_speed_pct),
    .dc_inject_out(dc_inject_out), .fan_fault_indication(fan_fault_indication),
    .life_alarm_out(life_alarm_out), .terminal_out(terminal_out), .irq(irq));
  plant_model plant_u (.clk(clk), .power_req(power_req), .supply_on(supply_on),
    .inrush_switch_on(inrush_switch_on));
  // Two-fan build: any single fan at half speed or less is a fault
  parts_life_alarm_monitor #(.FAN_COUNT(2), .DC_INJECT_CYCLES(20), .LIFE_TICK_CYCLES(4),
    .CTRL_CAP_STEP(16'h0002), .TERM_COUNT(3)) fan2_u (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(), .inrush_switch_on(inrush_switch_on),
    .supply_on(supply_on), .drive_running(drive_running), .heatsink_temp(heatsink_temp),
    .motor_connected(motor_connected), .motor_rotating(motor_rotating),
    .motor_undersized(motor_undersized), .run_command(run_command),
    .output_shutoff_input(output_shutoff_input), .fault_stop(fault_stop),
    .cap_measure_pct(cap_measure_pct), .fan_speed_pct(fan2_pct),
    .dc_inject_out(), .fan_fault_indication(fan2_fault),
    .life_alarm_out(), .terminal_out(), .irq());
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic close_out();
    if (n_mismatch == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Lowers both strobes; wr and rd each lower only the other one, so back-to-back accesses keep a strobe high
  task automatic idle(input int n);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    exp_q.push_back(e);
    reg_addr <= a;
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge clk);
  endtask
  task automatic wait_dc(input logic v);
    int n;
    n = 0;
    idle(1);
    while (dc_inject_out !== v && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    `CHK("dc_inject_out", v, dc_inject_out)
  endtask
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  // Read data stand only in the cycle after the strobe
  always @(negedge clk)
  begin
    if (chk)
    begin
      exp_v = exp_q.pop_front();
      `CHK("reg_rdata", exp_v, reg_rdata)
    end
    chk = reg_rd;
  end
  initial
  begin
    {rst, motor_connected, power_req} = 3'b111;
    {reg_wr, reg_rd, chk, drive_running, motor_rotating, motor_undersized} = '0;
    {run_command, output_shutoff_input, fault_stop, reg_addr, reg_wdata} = '0;
    {heatsink_temp, cap_measure_pct, fan_speed_pct} = {8'hf0, 7'h55, 7'h64};
    fan2_pct = {7'h64, 7'h64};
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    idle(4);
    for (i = 0; i < 16; i++)
      rd(i[3:0], (i > 0 && i < 4) ? 16'h0064 : 16'h0000);
    for (i = 0; i < 4; i++)
      wr(i[3:0], xs());
    for (i = 2; i < 10; i++)
      wr(4'h4, i[15:0]);
    for (i = 0; i < 5; i++)
      rd(i[3:0], (i > 0 && i < 4) ? 16'h0064 : 16'h0000);
    r = xs();
    fan_speed_pct <= 7'h29 + {2'b00, r[4:0]};
    wr(4'h5, 16'h005a);
    wr(4'h6, 16'h00be);
    wr(4'h7, 16'h0123);
    wr(4'h9, 16'h0004);
    rd(4'h5, 16'h005a);
    idle(8);
    `CHK("terminal_out", 3'b010, terminal_out)
    `CHK("fan_fault", 1'b0, fan_fault_indication)
    fan_speed_pct <= 7'h29;
    idle(8);
    `CHK("fan_fault", 1'b0, fan_fault_indication)
    fan_speed_pct <= 7'h28;
    idle(8);
    `CHK("fan_fault", 1'b1, fan_fault_indication)
    `CHK("life_alarm", 1'b1, life_alarm_out)
    `CHK("terminal_out", 3'b001, terminal_out)
    `CHK("irq", 1'b1, irq)
    rd(4'h0, 16'h0004);
    rd(4'h8, 16'h0004);
    rd(4'h0, 16'h0004);
    idle(4);
    `CHK("irq", 1'b0, irq)
    fan2_pct <= {7'h64, 7'h33};
    idle(8);
    `CHK("fan2_fault", 1'b0, fan2_fault)
    fan2_pct <= {7'h32, 7'h64};
    idle(8);
    `CHK("fan2_fault", 1'b1, fan2_fault)
    fan_speed_pct <= 7'h64;
    wr(4'h9, 16'h0010);
    wr(4'h4, 16'h0001);
    rd(4'h4, 16'h0001);
    // DC injection time is cut to 20 clocks in this bench
    power_req <= 1'b0;
    wait_dc(1'b1);
    wr(4'h4, 16'h0000);
    rd(4'h4, 16'h0002);
    wait_dc(1'b0);
    rd(4'h4, 16'h0003);
    rd(4'h3, 16'h0055);
    rd(4'h0, 16'h0002);
    idle(2);
    `CHK("irq", 1'b1, irq)
    rd(4'h8, 16'h0012);
    power_req <= 1'b1;
    idle(6);
    for (i = 0; i < 4; i++)
    begin
      wr(4'h4, 16'h0001);
      power_req <= 1'b0;
      wait_dc(1'b1);
      if (i == 0)
        power_req <= 1'b1;
      else
        {fault_stop, output_shutoff_input, run_command} <= 3'(1 << (i - 1));
      wait_dc(1'b0);
      rd(4'h4, 16'h0008);
      {power_req, fault_stop, output_shutoff_input, run_command} <= 4'h8;
      idle(6);
    end
    for (i = 0; i < 3; i++)
    begin
      {motor_connected, motor_rotating, motor_undersized} <= 3'b100 ^ (3'b100 >> i);
      wr(4'h4, 16'h0001);
      power_req <= 1'b0;
      idle(12);
      `CHK("dc_inject_out", 1'b0, dc_inject_out)
      rd(4'h4, 16'h0009);
      {power_req, motor_connected, motor_rotating, motor_undersized} <= 4'hc;
      idle(6);
    end
    drive_running <= 1'b1;
    idle(600);
    drive_running <= 1'b0;
    idle(4);
    rd(4'h2, 16'h0000);
    rd(4'h0, 16'h0003);
    rd(4'h1, 16'h0064);
    idle(4);
    `CHK("terminal_out", 3'b001, terminal_out)
    close_out();
  end
endmodule

/* dv/parts_life_checker_assertions.sv */
// Port-level timing checks for the parts life monitor
`timescale 1ns/1ps
module parts_life_checker #(
  parameter DC_INJECT_CYCLES = 20,
  parameter TERM_COUNT       = 3
) (
  input logic                  clk,
  input logic                  rst,
  input logic                  reg_wr,
  input logic                  reg_rd,
  input logic [15:0]           reg_rdata,
  input logic                  supply_on,
  input logic                  motor_connected,
  input logic                  motor_rotating,
  input logic                  motor_undersized,
  input logic                  run_command,
  input logic                  output_shutoff_input,
  input logic                  fault_stop,
  input logic                  dc_inject_out,
  input logic                  life_alarm_out,
  input logic [TERM_COUNT-1:0] terminal_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] dc_cnt;
  logic        abort_seen;
  wire         cmd_stop = run_command | output_shutoff_input | fault_stop;
  // An aborted injection is legally short, so the length check skips it
  always @(posedge clk)
  begin
    dc_cnt     <= (rst || !dc_inject_out) ? 32'h0 : dc_cnt + 32'h1;
    abort_seen <= (rst || !dc_inject_out) ? 1'b0 : abort_seen | cmd_stop | supply_on;
  end
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data present without a read");
  a_power_abort: assert property (dc_inject_out && supply_on |-> ##[1:4] !dc_inject_out)
    else $error("injection kept after power returned");
  a_cmd_abort: assert property (dc_inject_out && cmd_stop |-> ##[1:4] !dc_inject_out)
    else $error("injection kept after run, shutoff or fault");
  a_dc_max: assert property (dc_inject_out |-> dc_cnt < DC_INJECT_CYCLES)
    else $error("injection too long");
  a_dc_full: assert property ($fell(dc_inject_out) && !abort_seen |-> dc_cnt == DC_INJECT_CYCLES)
    else $error("injection length wrong");
  a_dc_after_off: assert property ($rose(dc_inject_out) |-> !supply_on && !$past(supply_on))
    else $error("injection without supply loss");
  a_dc_motor_ok: assert property ($rose(dc_inject_out) |->
      motor_connected && !motor_rotating && !motor_undersized)
    else $error("injection with unfit motor");
  a_term_cause: assert property ($changed(terminal_out) |-> $changed(life_alarm_out) ||
      $past(life_alarm_out) != $past(life_alarm_out, 2) || $past(reg_wr) || $past(reg_wr, 2))
    else $error("terminal changed without cause");
endmodule
bind parts_life_alarm_monitor parts_life_checker #(
  .DC_INJECT_CYCLES(DC_INJECT_CYCLES),
  .TERM_COUNT(TERM_COUNT)
) chk_u (
  .clk(clk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .supply_on(supply_on), .motor_connected(motor_connected), .motor_rotating(motor_rotating),
  .motor_undersized(motor_undersized), .run_command(run_command),
  .output_shutoff_input(output_shutoff_input), .fault_stop(fault_stop),
  .dc_inject_out(dc_inject_out), .life_alarm_out(life_alarm_out), .terminal_out(terminal_out)
);

/* dv/plant_model.sv */
// Mains supply and inrush contactor seen from the drive
`timescale 1ns/1ps
module plant_model (
  input  logic clk,
  input  logic power_req,
  output logic supply_on,
  output logic inrush_switch_on
);
  logic [7:0] on_cnt;
  initial
  begin
    supply_on = 1'b1;
    inrush_switch_on = 1'b0;
    on_cnt = 8'h00;
  end
  // Supply returns only when the controller asks for it
  always @(posedge clk)
  begin
    supply_on <= power_req;
    on_cnt <= !power_req ? 8'h00 : (on_cnt == 8'hff ? on_cnt : on_cnt + 8'h01);
    // One contact closure per power-up, four clocks after supply returns and held while it stays on
    inrush_switch_on <= power_req && on_cnt >= 8'h04;
  end
endmodule

/* include/parts_life_consts.vh */
// Offsets, field positions, reset values and timing counts of the parts life monitor
`ifndef PARTS_LIFE_CONSTS_VH
`define PARTS_LIFE_CONSTS_VH

`define CLK_FREQ_HZ          125000000
`define DC_INJECT_TIME_MS    1000
`define LIFE_TICK_TIME_MS    1000

`define ADDR_PARTS_LIFE_STATUS   4'h0
`define ADDR_INRUSH_LIFE         4'h1
`define ADDR_CTRL_CAP_LIFE       4'h2
`define ADDR_MAIN_CAP_LIFE       4'h3
`define ADDR_MEASURE_CONTROL     4'h4
`define ADDR_TERM_SELECT_0       4'h5
`define ADDR_TERM_SELECT_1       4'h6
`define ADDR_TERM_SELECT_2       4'h7
`define ADDR_IRQ_STATUS          4'h8
`define ADDR_IRQ_MASK            4'h9

`define BIT_CTRL_CAP     0
`define BIT_MAIN_CAP     1
`define BIT_FAN          2
`define BIT_INRUSH       3
`define BIT_MEASURE_END  4

`define PERCENT_FULL         7'h64
`define INRUSH_ALARM_PCT     7'h0a
`define CTRL_CAP_ALARM_PCT   7'h0a
`define MAIN_CAP_ALARM_PCT   7'h55
`define FAN_ALARM_PCT_ONE    7'h28
`define FAN_ALARM_PCT_MULTI  7'h32
`define INRUSH_EVENTS_PER_PCT 10000

`define MEAS_NONE      4'h0
`define MEAS_START     4'h1
`define MEAS_RUNNING   4'h2
`define MEAS_DONE      4'h3
`define MEAS_FORCED    4'h8
`define MEAS_ERROR     4'h9

`define TERM_CODE_POS  9'h05a
`define TERM_CODE_NEG  9'h0be
`define TERM_SELECT_RESET 9'h000

`endif

/* rtl/parts_life_alarm_monitor.v */
// Life monitor for inrush contacts, capacitors and fan, with alarm routing
//
// The implementer's own choices: the register offsets and the plain strobed port.
`timescale 1ns/1ps
`include "parts_life_consts.vh"
// Contract
// - Four-bit read-only life status, one bit per worn-out part
// - Combined life alarm high whenever any part reached its alarm level
// - Terminal select code 90 routes alarm, 190 routes it inverted
// - Count contact switch-ons; life drops one percent per 10,000 events
// - At 10% inrush life (900,000 events) set bit 3 and alarm
// - While operating, estimate control capacitor life from time and temperature
// - Control capacitor life below 10% sets bit 0 and alarm
// - Each completed measurement updates main capacitor life; at 85% or less bit 1
// - Measure field codes 0,1,2,3,8,9; only 0 and 1 are writable
// - Measure field at 1 and supply removed starts the measurement
// - During power-off measurement drive DC onto motor for 1 s
// - Power back, run, output shutoff or fault during measuring gives code 8
// - Motor absent, rotating or too small gives error code 9
// - Early power return may leave code 2; controller restarts from start code
// - Fan speed at or below 40% shows fan fault, sets bit 2 and alarm
// - With several fans, any fan at or below 50% shows fan fault
module parts_life_alarm_monitor #(
  parameter FAN_COUNT        = 1,
  parameter DC_INJECT_CYCLES = `DC_INJECT_TIME_MS * (`CLK_FREQ_HZ / 1000),
  parameter LIFE_TICK_CYCLES = `LIFE_TICK_TIME_MS * (`CLK_FREQ_HZ / 1000),
  parameter CTRL_CAP_STEP    = 16'h4000,
  parameter TERM_COUNT       = 3
) (
  input  wire                   clk,
  input  wire                   rst,
  input  wire [3:0]             reg_addr,
  input  wire [15:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [15:0]            reg_rdata,
  input  wire                   inrush_switch_on,
  input  wire                   supply_on,
  input  wire                   drive_running,
  input  wire [7:0]             heatsink_temp,
  input  wire                   motor_connected,
  input  wire                   motor_rotating,
  input  wire                   motor_undersized,
  input  wire                   run_command,
  input  wire                   output_shutoff_input,
  input  wire                   fault_stop,
  input  wire [6:0]             cap_measure_pct,
  input  wire [FAN_COUNT*7-1:0] fan_speed_pct,
  output reg                    dc_inject_out,
  output reg                    fan_fault_indication,
  output reg                    life_alarm_out,
  output reg  [TERM_COUNT-1:0]  terminal_out,
  output reg                    irq
);

  localparam SYNC_W = 17 + FAN_COUNT * 7;

  // One-hot measurement states
  localparam [5:0] ST_IDLE    = 6'h01;
  localparam [5:0] ST_ARMED   = 6'h02;
  localparam [5:0] ST_MEASURE = 6'h04;
  localparam [5:0] ST_DONE    = 6'h08;
  localparam [5:0] ST_FORCED  = 6'h10;
  localparam [5:0] ST_ERROR   = 6'h20;

  function [6:0] dec_floor;
    input [6:0] pct;
    begin
      dec_floor = (pct == 7'h00) ? 7'h00 : pct - 7'h01;
    end
  endfunction

  function [8:0] term_code;
    input [15:0] data;
    begin
      term_code = data[8:0];
    end
  endfunction

  // Every outside input except the register port passes two flip-flops before use
  wire [SYNC_W-1:0] sync_in = {fan_speed_pct, cap_measure_pct, heatsink_temp,
                               inrush_switch_on, fault_stop};
  reg  [SYNC_W-1:0] sync1_reg;
  reg  [SYNC_W-1:0] sync2_reg;
  reg  [7:0]        lvl1_reg;
  reg  [7:0]        lvl2_reg;

  // Fan fields reset to a healthy speed: a zero there would read as a
  // stalled fan while the flops flush and latch a false interrupt event
  localparam [SYNC_W-1:0] SYNC_RST = {{(FAN_COUNT * 7){1'b1}}, 17'h00000};

  always @(posedge clk)
  begin
    if (rst)
    begin
      sync1_reg <= SYNC_RST;
      sync2_reg <= SYNC_RST;
      lvl1_reg  <= 8'h00;
      lvl2_reg  <= 8'h00;
    end
    else
    begin
      sync1_reg <= sync_in;
      sync2_reg <= sync1_reg;
      lvl1_reg  <= {supply_on, drive_running, motor_connected, motor_rotating,
                    motor_undersized, run_command, output_shutoff_input, 1'b0};
      lvl2_reg  <= lvl1_reg;
    end
  end

  wire                   s_fault    = sync2_reg[0];
  wire                   s_inrush   = sync2_reg[1];
  wire [7:0]             s_temp     = sync2_reg[9:2];
  wire [6:0]             s_cap_pct  = sync2_reg[16:10];
  wire [FAN_COUNT*7-1:0] s_fan      = sync2_reg[SYNC_W-1:17];
  wire                   s_supply   = lvl2_reg[7];
  wire                   s_running  = lvl2_reg[6];
  wire                   s_motor_ok = lvl2_reg[5];
  wire                   s_rotating = lvl2_reg[4];
  wire                   s_small    = lvl2_reg[3];
  wire                   s_run_cmd  = lvl2_reg[2];
  wire                   s_shutoff  = lvl2_reg[1];

  reg        inrush_prev_reg;
  reg        supply_prev_reg;
  reg [13:0] inrush_sub_reg;
  reg [6:0]  inrush_pct_reg;
  reg [31:0] tick_cnt_reg;
  reg [15:0] ctrl_acc_reg;
  reg [6:0]  ctrl_pct_reg;
  reg [6:0]  main_pct_reg;
  reg [5:0]  meas_state_reg;
  reg [5:0]  meas_state_next;
  reg [31:0] inject_cnt_reg;
  reg [8:0]  term_sel_reg [0:TERM_COUNT-1];
  reg [4:0]  irq_status_reg;
  reg [4:0]  irq_mask_reg;
  reg [3:0]  life_prev_reg;

  wire inrush_edge = s_inrush & ~inrush_prev_reg;
  wire supply_lost = supply_prev_reg & ~s_supply;
  // Free-running tick; the estimate only advances while the drive runs
  wire tick        = (tick_cnt_reg == LIFE_TICK_CYCLES - 1);
  wire [15:0] ctrl_weight = {11'h000, s_temp[7:4]} + 16'h0001;
  wire meas_wr     = reg_wr && (reg_addr == `ADDR_MEASURE_CONTROL);
  wire meas_wr_ok  = meas_wr && (reg_wdata[3:0] == `MEAS_NONE ||
                                 reg_wdata[3:0] == `MEAS_START);
  // Any of these ends an injection at once; the motor must not see DC with power back
  wire abort_cond  = s_supply | s_run_cmd | s_shutoff | s_fault;
  wire inject_end  = (inject_cnt_reg == DC_INJECT_CYCLES - 1);

  // Fan check: single fan uses the lower threshold, any of several the higher one
  reg fan_low;
  integer fi;
  always @*
  begin
    fan_low = 1'b0;
    for (fi = 0; fi < FAN_COUNT; fi = fi + 1)
    begin
      if (FAN_COUNT == 1)
      begin
        if (s_fan[fi*7 +: 7] <= `FAN_ALARM_PCT_ONE)
          fan_low = 1'b1;
      end
      else if (s_fan[fi*7 +: 7] <= `FAN_ALARM_PCT_MULTI)
        fan_low = 1'b1;
    end
  end

  // Status is a level of each part's current condition, so it holds while worn
  wire [3:0] life_status;
  assign life_status[`BIT_INRUSH]   = (inrush_pct_reg <= `INRUSH_ALARM_PCT);
  assign life_status[`BIT_CTRL_CAP] = (ctrl_pct_reg < `CTRL_CAP_ALARM_PCT);
  assign life_status[`BIT_MAIN_CAP] = (main_pct_reg <= `MAIN_CAP_ALARM_PCT);
  assign life_status[`BIT_FAN]      = fan_low;

  // Inrush contact wear
  always @(posedge clk)
  begin
    if (rst)
    begin
      inrush_prev_reg <= 1'b0;
      inrush_sub_reg  <= 14'h0000;
      inrush_pct_reg  <= `PERCENT_FULL;
    end
    else
    begin
      inrush_prev_reg <= s_inrush;
      if (inrush_edge)
      begin
        if (inrush_sub_reg == `INRUSH_EVENTS_PER_PCT - 1)
        begin
          inrush_sub_reg <= 14'h0000;
          inrush_pct_reg <= dec_floor(inrush_pct_reg);
        end
        else
          inrush_sub_reg <= inrush_sub_reg + 14'h0001;
      end
    end
  end

  // Control capacitor estimate: hotter heatsink ages the capacitor faster
  always @(posedge clk)
  begin
    if (rst)
    begin
      tick_cnt_reg <= 32'h00000000;
      ctrl_acc_reg <= 16'h0000;
      ctrl_pct_reg <= `PERCENT_FULL;
    end
    else
    begin
      tick_cnt_reg <= tick ? 32'h00000000 : tick_cnt_reg + 32'h00000001;
      if (tick && s_running)
      begin
        // Accumulator restarts at each step, so a large weight never skips a percent
        if (ctrl_acc_reg + ctrl_weight >= CTRL_CAP_STEP)
        begin
          ctrl_acc_reg <= 16'h0000;
          ctrl_pct_reg <= dec_floor(ctrl_pct_reg);
        end
        else
          ctrl_acc_reg <= ctrl_acc_reg + ctrl_weight;
      end
    end
  end

  // Main capacitor measurement sequence
  always @*
  begin
    meas_state_next = meas_state_reg;
    case (meas_state_reg)
      ST_IDLE, ST_DONE, ST_FORCED, ST_ERROR:
      begin
        if (meas_wr_ok)
          meas_state_next = (reg_wdata[3:0] == `MEAS_START) ? ST_ARMED : ST_IDLE;
      end
      ST_ARMED:
      begin
        if (meas_wr_ok && reg_wdata[3:0] == `MEAS_NONE)
          meas_state_next = ST_IDLE;
        else if (supply_lost)
        begin
          // Motor fitness is judged once, at the moment supply goes
          if (!s_motor_ok || s_rotating || s_small)
            meas_state_next = ST_ERROR;
          else
            meas_state_next = ST_MEASURE;
        end
      end
      ST_MEASURE:
      begin
        if (abort_cond)
          meas_state_next = ST_FORCED;
        else if (inject_end)
          meas_state_next = ST_DONE;
      end
      default:
        meas_state_next = ST_IDLE;
    endcase
  end

  reg [3:0] meas_code;
  always @*
  begin
    case (meas_state_reg)
      ST_ARMED:   meas_code = `MEAS_START;
      ST_MEASURE: meas_code = `MEAS_RUNNING;
      ST_DONE:    meas_code = `MEAS_DONE;
      ST_FORCED:  meas_code = `MEAS_FORCED;
      ST_ERROR:   meas_code = `MEAS_ERROR;
      default:    meas_code = `MEAS_NONE;
    endcase
  end

  always @(posedge clk)
  begin
    if (rst)
    begin
      supply_prev_reg <= 1'b0;
      meas_state_reg  <= ST_IDLE;
      inject_cnt_reg  <= 32'h00000000;
      main_pct_reg    <= `PERCENT_FULL;
      dc_inject_out   <= 1'b0;
    end
    else
    begin
      supply_prev_reg <= s_supply;
      meas_state_reg  <= meas_state_next;
      // Driven from the next state so the pin follows the state with no extra cycle
      dc_inject_out   <= (meas_state_next == ST_MEASURE);
      if (meas_state_reg == ST_MEASURE)
        inject_cnt_reg <= inject_cnt_reg + 32'h00000001;
      else
        inject_cnt_reg <= 32'h00000000;
      // A reading above the factory value is clamped; the field only shows 0 to 100
      if (meas_state_reg == ST_MEASURE && meas_state_next == ST_DONE)
        main_pct_reg <= (s_cap_pct > `PERCENT_FULL) ? `PERCENT_FULL : s_cap_pct;
    end
  end

  // Alarm, fan indication, terminal routing and interrupt
  wire [4:0] irq_events = {meas_state_next != meas_state_reg &&
                           (meas_state_next == ST_DONE || meas_state_next == ST_FORCED ||
                            meas_state_next == ST_ERROR),
                           life_status & ~life_prev_reg};
  wire irq_rd_clear = reg_rd && (reg_addr == `ADDR_IRQ_STATUS);
  integer ti;

  always @(posedge clk)
  begin
    if (rst)
    begin
      life_prev_reg        <= 4'h0;
      life_alarm_out       <= 1'b0;
      fan_fault_indication <= 1'b0;
      terminal_out         <= {TERM_COUNT{1'b0}};
      irq_status_reg       <= 5'h00;
      irq_mask_reg         <= 5'h00;
      irq                  <= 1'b0;
      for (ti = 0; ti < TERM_COUNT; ti = ti + 1)
        term_sel_reg[ti] <= `TERM_SELECT_RESET;
    end
    else
    begin
      life_prev_reg        <= life_status;
      life_alarm_out       <= |life_status;
      fan_fault_indication <= fan_low;
      for (ti = 0; ti < TERM_COUNT; ti = ti + 1)
      begin
        // Unknown select codes park the terminal low rather than guess a function
        if (term_sel_reg[ti] == `TERM_CODE_POS)
          terminal_out[ti] <= |life_status;
        else if (term_sel_reg[ti] == `TERM_CODE_NEG)
          terminal_out[ti] <= ~(|life_status);
        else
          terminal_out[ti] <= 1'b0;
        if (reg_wr && reg_addr == `ADDR_TERM_SELECT_0 + ti[3:0])
          term_sel_reg[ti] <= term_code(reg_wdata);
      end
      // A new event in the reading cycle survives the clear
      irq_status_reg <= (irq_rd_clear ? 5'h00 : irq_status_reg) | irq_events;
      if (reg_wr && reg_addr == `ADDR_IRQ_MASK)
        irq_mask_reg <= reg_wdata[4:0];
      irq <= |(((irq_rd_clear ? 5'h00 : irq_status_reg) | irq_events) & irq_mask_reg);
    end
  end

  // Register read port, data one cycle after the strobe
  always @(posedge clk)
  begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_PARTS_LIFE_STATUS: reg_rdata <= {12'h000, life_status};
        `ADDR_INRUSH_LIFE:       reg_rdata <= {9'h000, inrush_pct_reg};
        `ADDR_CTRL_CAP_LIFE:     reg_rdata <= {9'h000, ctrl_pct_reg};
        `ADDR_MAIN_CAP_LIFE:     reg_rdata <= {9'h000, main_pct_reg};
        `ADDR_MEASURE_CONTROL:   reg_rdata <= {12'h000, meas_code};
        `ADDR_TERM_SELECT_0:     reg_rdata <= {7'h00, term_sel_reg[0]};
        // Indices wrap when fewer terminals are built, so reads never run off the array
        `ADDR_TERM_SELECT_1:     reg_rdata <= {7'h00, term_sel_reg[1 % TERM_COUNT]};
        `ADDR_TERM_SELECT_2:     reg_rdata <= {7'h00, term_sel_reg[2 % TERM_COUNT]};
        `ADDR_IRQ_STATUS:        reg_rdata <= {11'h000, irq_status_reg};
        `ADDR_IRQ_MASK:          reg_rdata <= {11'h000, irq_mask_reg};
        default:                 reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

endmodule
